//--- design/drc_reference_control.sv
// Register file, pin override and ladder control of the reference converter
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module drc_reference_control
    import drc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire drc_bus_t          bus_req,
    output logic [DATA_W-1:0]      rd_data,
    output var  drc_ladder_t       ladder_ctl,
    output var  drc_mode_t         ladder_mode,
    input  wire logic              pin_level_in,
    input  wire logic              pin_digital_oe_req,
    output logic                   pin_read_value,
    output logic                   pin_digital_oe
);

    drc_state_t  st_q;
    drc_state_t  st_d;
    drc_ladder_t map_ladder;
    drc_mode_t   map_mode;
    logic        wr_main;
    logic        wr_level;
    logic        rd_status;
    logic        rst_seen_q;

    assign wr_main   = bus_req.wr && (bus_req.addr == OFS_MAIN);
    assign wr_level  = bus_req.wr && (bus_req.addr == OFS_LEVEL);
    assign rd_status = bus_req.rd && (bus_req.addr == OFS_STATUS);

    drc_ladder_map u_map (
        .ctl    (st_q.ctl),
        .level  (st_q.level),
        .ladder (map_ladder),
        .mode   (map_mode)
    );

    always_comb begin
        st_d         = st_q;
        st_d.rd_data = '0;

        // Only implemented fields are stored, so reserved bits can never be set
        if (wr_main) begin
            st_d.ctl = drc_unpack_ctl(bus_req.wdata);
        end
        if (wr_level) begin
            st_d.level = bus_req.wdata[LVL_POS +: LVL_W];
        end

        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_MAIN: begin
                    st_d.rd_data = drc_pack_ctl(st_q.ctl);
                end
                OFS_LEVEL: begin
                    st_d.rd_data = {{(DATA_W-LVL_W){1'b0}}, st_q.level};
                end
                OFS_STATUS: begin
                    st_d.rd_data = drc_pack_status(st_q);
                end
                default: begin
                    st_d.rd_data = '0;
                end
            endcase
        end

        // Switches follow the stored fields one cycle late, never a half-done write
        st_d.ladder = map_ladder;
        st_d.mode   = map_mode;

        st_d.clamp_hi = !st_q.ctl.converter_enable && st_q.ctl.low_power_end_select
                        && (st_q.level == LVL_ONES);
        st_d.clamp_lo = !st_q.ctl.converter_enable && !st_q.ctl.low_power_end_select
                        && (st_q.level == LVL_ZERO);
        st_d.src_rsvd = (st_q.ctl.positive_source_select == PSS_RSVD);

        // Pin in analog use: digital read path forced low
        st_d.pin_rd = st_q.ctl.level_pin_drive_enable ? 1'b0 : pin_level_in;
    end

    // Only a bus write or rst_n changes the fields, so a Sleep wake-up leaves them intact
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data        = st_q.rd_data;
    assign ladder_ctl     = st_q.ladder;
    assign ladder_mode    = st_q.mode;
    assign pin_read_value = st_q.pin_rd;
    // Analog output overrides the digital driver of the shared pin
    assign pin_digital_oe = pin_digital_oe_req && !st_q.ladder.pin_drive;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_seen_q <= 1'b1;
        end else begin
            rst_seen_q <= 1'b0;
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking

    default disable iff (!rst_n);

    lower_drop_a: assert property (
        !st_q.ctl.converter_enable && st_q.ctl.low_power_end_select
        |=> !ladder_ctl.lower_end_on && ladder_ctl.upper_end_on
            && ladder_mode == MODE_LOWER_OFF
    ) else $error("lower ladder end not dropped in low-power state");

    upper_drop_a: assert property (
        !st_q.ctl.converter_enable && !st_q.ctl.low_power_end_select
        |=> !ladder_ctl.upper_end_on && ladder_ctl.lower_end_on
            && ladder_mode == MODE_UPPER_OFF
    ) else $error("upper ladder end not dropped in low-power state");

    ctl_hold_a: assert property (
        !wr_main |=> $stable(st_q.ctl)
    ) else $error("control fields changed without a write");

    reset_state_a: assert property (
        rst_seen_q |-> !st_q.ctl.converter_enable && !st_q.ctl.level_pin_drive_enable
            && !ladder_ctl.pin_drive && st_q.level == LEVEL_RST && ladder_ctl.tap == LEVEL_RST
    ) else $error("converter not idle after reset");

    enable_on_a: assert property (
        wr_main && bus_req.wdata[EN_POS]
        |=> st_q.ctl.converter_enable
        ##1 ladder_ctl.upper_end_on && ladder_ctl.lower_end_on
            && ladder_mode == MODE_ACTIVE
    ) else $error("enable write did not close both ladder ends");

    src_fixed_a: assert property (
        st_q.ctl.positive_source_select == PSS_FIXED |=> ladder_ctl.upper_src == SRC_FIXED
    ) else $error("fixed buffer source not selected");

    src_ext_a: assert property (
        st_q.ctl.positive_source_select == PSS_EXT |=> ladder_ctl.upper_src == SRC_EXT
    ) else $error("external positive source not selected");

    src_rsvd_a: assert property (
        st_q.ctl.positive_source_select == PSS_RSVD |=> ladder_ctl.upper_src == SRC_NONE
    ) else $error("reserved source code closed a switch");

    neg_src_a: assert property (
        1'b1 |=> ladder_ctl.lower_ext == $past(st_q.ctl.negative_source_select)
    ) else $error("negative source select not followed");

    level_tap_a: assert property (
        wr_level |=> ##1 ladder_ctl.tap == $past(bus_req.wdata[LVL_W-1:0], 2)
    ) else $error("ladder tap does not follow level write");

    main_rsvd_a: assert property (
        bus_req.rd && bus_req.addr == OFS_MAIN
        |=> (rd_data & MAIN_RSVD) == '0
            && rd_data == drc_pack_ctl($past(st_q.ctl))
    ) else $error("first register read back wrong");

    level_rsvd_a: assert property (
        bus_req.rd && bus_req.addr == OFS_LEVEL
        |=> rd_data[DATA_W-1:LVL_W] == '0 && rd_data[LVL_W-1:0] == $past(st_q.level)
    ) else $error("second register read back wrong");

    pin_quiet_a: assert property (
        ladder_ctl.pin_drive |-> !pin_read_value && !pin_digital_oe
    ) else $error("pin digital path active while level is routed out");

    pin_route_a: assert property (
        wr_main && bus_req.wdata[OE_POS] ##1 !wr_main
        |=> ladder_ctl.pin_drive ##1 !pin_read_value
    ) else $error("pin drive enable not applied");

    wr_follow_a: assert property (
        wr_main
        |=> st_q.ctl == drc_unpack_ctl($past(bus_req.wdata))
        ##1 ladder_ctl.pin_drive == $past(st_q.ctl.level_pin_drive_enable)
            && ladder_ctl.lower_ext == $past(st_q.ctl.negative_source_select)
    ) else $error("write not stored or not applied one cycle later");

    rd_once_a: assert property (
        !bus_req.rd |=> rd_data == '0
    ) else $error("read data stands outside its cycle");

    status_rd_a: assert property (
        rd_status
        |=> rd_data[STS_CHI_POS] == $past(st_q.clamp_hi)
            && rd_data[STS_CLO_POS] == $past(st_q.clamp_lo)
            && rd_data[STS_MODE_POS +: 3] == $past(ladder_mode)
    ) else $error("status read does not show mode and clamp flags");

endmodule : drc_reference_control

`default_nettype wire

//--- design/drc_pkg.sv
// Constants, types and helpers of the reference converter control block
// Functional notes
// - Low-power select one drops lower ladder end; zero drops upper end.
// - First control register keeps all bits across Sleep wake-up.
// - Reset disables converter and disconnects output from its pin.
// - Reset clears the five-bit output level field.
// - Converter enable is bit 7 of first register; one enables.
// - Positive source bits 3:2: supply, external, fixed buffer, reserved.
// - Negative source bit 0: one external reference, zero ground.
// - Level bits 4:0 of second register pick ladder tap out of 32.
// - Unimplemented bits ignore writes and read as zero.
// - Pin drive bit 5 routes level to pin; pin reads return zero.
package drc_pkg;

    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LVL_W  = 5;

    localparam logic [ADDR_W-1:0] OFS_MAIN   = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_LEVEL  = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h2;

    localparam int unsigned EN_POS  = 7;
    localparam int unsigned LPS_POS = 6;
    localparam int unsigned OE_POS  = 5;
    localparam int unsigned PSS_POS = 2;
    localparam int unsigned NSS_POS = 0;
    localparam int unsigned LVL_POS = 0;

    localparam int unsigned STS_MODE_POS = 0;
    localparam int unsigned STS_CHI_POS  = 3;
    localparam int unsigned STS_CLO_POS  = 4;
    localparam int unsigned STS_RSV_POS  = 5;

    localparam logic [DATA_W-1:0] MAIN_RSVD = 8'h12;
    localparam logic [LVL_W-1:0]  LEVEL_RST = 5'h00;
    localparam logic [LVL_W-1:0]  LVL_ONES  = 5'h1F;
    localparam logic [LVL_W-1:0]  LVL_ZERO  = 5'h00;

    localparam logic [1:0] PSS_SUPPLY = 2'h0;
    localparam logic [1:0] PSS_EXT    = 2'h1;
    localparam logic [1:0] PSS_FIXED  = 2'h2;
    localparam logic [1:0] PSS_RSVD   = 2'h3;

    localparam logic [2:0] SRC_NONE   = 3'h0;
    localparam logic [2:0] SRC_SUPPLY = 3'h1;
    localparam logic [2:0] SRC_EXT    = 3'h2;
    localparam logic [2:0] SRC_FIXED  = 3'h4;

    typedef enum logic [2:0] {
        MODE_ACTIVE    = 3'b001,
        MODE_LOWER_OFF = 3'b010,
        MODE_UPPER_OFF = 3'b100
    } drc_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } drc_bus_t;

    typedef struct packed {
        logic       converter_enable;
        logic       low_power_end_select;
        logic       level_pin_drive_enable;
        logic [1:0] positive_source_select;
        logic       negative_source_select;
    } drc_ctl_t;

    typedef struct packed {
        logic [2:0]       upper_src;
        logic             lower_ext;
        logic             upper_end_on;
        logic             lower_end_on;
        logic [LVL_W-1:0] tap;
        logic             pin_drive;
    } drc_ladder_t;

    typedef struct packed {
        drc_ctl_t          ctl;
        logic [LVL_W-1:0]  level;
        drc_mode_t         mode;
        drc_ladder_t       ladder;
        logic [DATA_W-1:0] rd_data;
        logic              clamp_hi;
        logic              clamp_lo;
        logic              src_rsvd;
        logic              pin_rd;
    } drc_state_t;

    localparam drc_ladder_t LADDER_RST = '{upper_src: SRC_SUPPLY, lower_ext: 1'b0,
        upper_end_on: 1'b0, lower_end_on: 1'b1, tap: LEVEL_RST, pin_drive: 1'b0};

    localparam drc_state_t ST_RST = '{ctl: '0, level: LEVEL_RST, mode: MODE_UPPER_OFF,
        ladder: LADDER_RST, rd_data: '0, clamp_hi: 1'b0, clamp_lo: 1'b1,
        src_rsvd: 1'b0, pin_rd: 1'b0};

    function automatic logic [DATA_W-1:0] drc_pack_ctl(input drc_ctl_t c);
        logic [DATA_W-1:0] b;
        b                 = '0;
        b[EN_POS]         = c.converter_enable;
        b[LPS_POS]        = c.low_power_end_select;
        b[OE_POS]         = c.level_pin_drive_enable;
        b[PSS_POS +: 2]   = c.positive_source_select;
        b[NSS_POS]        = c.negative_source_select;
        return b;
    endfunction : drc_pack_ctl

    function automatic drc_ctl_t drc_unpack_ctl(input logic [DATA_W-1:0] b);
        drc_ctl_t c;
        c.converter_enable       = b[EN_POS];
        c.low_power_end_select   = b[LPS_POS];
        c.level_pin_drive_enable = b[OE_POS];
        c.positive_source_select = b[PSS_POS +: 2];
        c.negative_source_select = b[NSS_POS];
        return c;
    endfunction : drc_unpack_ctl

    function automatic logic [DATA_W-1:0] drc_pack_status(input drc_state_t s);
        logic [DATA_W-1:0] b;
        b                     = '0;
        b[STS_MODE_POS +: 3]  = s.mode;
        b[STS_CHI_POS]        = s.clamp_hi;
        b[STS_CLO_POS]        = s.clamp_lo;
        b[STS_RSV_POS]        = s.src_rsvd;
        return b;
    endfunction : drc_pack_status

endpackage : drc_pkg

//--- design/drc_ladder_map.sv
// Maps stored control fields onto ladder switch controls and ladder mode
`timescale 1ns/1ps
`default_nettype none

module drc_ladder_map
    import drc_pkg::*;
(
    input  wire drc_ctl_t         ctl,
    input  wire logic [LVL_W-1:0] level,
    output var  drc_ladder_t      ladder,
    output var  drc_mode_t        mode
);

    always_comb begin
        ladder           = '0;
        ladder.tap       = level;
        ladder.pin_drive = ctl.level_pin_drive_enable;
        ladder.lower_ext = ctl.negative_source_select;
        case (ctl.positive_source_select)
            PSS_SUPPLY: ladder.upper_src = SRC_SUPPLY;
            PSS_EXT:    ladder.upper_src = SRC_EXT;
            PSS_FIXED:  ladder.upper_src = SRC_FIXED;
            default:    ladder.upper_src = SRC_NONE;
        endcase
        // Reserved source code opens every upper switch rather than guess a source
        if (ctl.converter_enable) begin
            mode                = MODE_ACTIVE;
            ladder.upper_end_on = 1'b1;
            ladder.lower_end_on = 1'b1;
        end else if (ctl.low_power_end_select) begin
            mode                = MODE_LOWER_OFF;
            ladder.upper_end_on = 1'b1;
            ladder.lower_end_on = 1'b0;
        end else begin
            mode                = MODE_UPPER_OFF;
            ladder.upper_end_on = 1'b0;
            ladder.lower_end_on = 1'b1;
        end
    end

endmodule : drc_ladder_map

`default_nettype wire

//--- dv/drc_ladder_model.sv
// Behavioural model of the resistor ladder and its two source ends
`timescale 1ns/1ps
`default_nettype none

module drc_ladder_model
    import drc_pkg::*;
#(
    parameter int VDD_MV  = 3300,
    parameter int VREF_MV = 2000,
    parameter int FIX_MV  = 1024,
    parameter int VNEG_MV = 400
)(
    input  wire drc_ladder_t ladder,
    output var  int          vout_mv
);
    int hi;
    int lo;

    always_comb begin
        hi = (ladder.upper_src == SRC_SUPPLY) ? VDD_MV :
             (ladder.upper_src == SRC_EXT) ? VREF_MV :
             (ladder.upper_src == SRC_FIXED) ? FIX_MV : 0;
        lo = ladder.lower_ext ? VNEG_MV : 0;
        // One open end stops the current, so the tap floats to the connected end
        if (ladder.upper_end_on && ladder.lower_end_on) begin
            vout_mv = lo + (hi - lo) * int'(ladder.tap) / 32;
        end else if (ladder.upper_end_on) begin
            vout_mv = hi;
        end else if (ladder.lower_end_on) begin
            vout_mv = lo;
        end else begin
            vout_mv = -7;
        end
    end

endmodule : drc_ladder_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the reference converter control block
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import drc_pkg::*;
;
    localparam int VDD = 3300;
    localparam int VRP = 2000;
    localparam int FIX = 1024;
    localparam int VNG = 400;

    logic              ref_clk;
    logic              rst_n;
    drc_bus_t          bus_req;
    logic [DATA_W-1:0] rd_data;
    drc_ladder_t       ladder_ctl;
    drc_mode_t         ladder_mode;
    logic              pin_level_in;
    logic              pin_digital_oe_req;
    logic              pin_read_value;
    logic              pin_digital_oe;
    int                vout_mv;
    int                err_total;
    int                compares;
    logic [DATA_W-1:0] rv;

    drc_reference_control i_drc_reference_control (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_req(bus_req), .rd_data(rd_data), .ladder_ctl(ladder_ctl),
        .ladder_mode(ladder_mode), .pin_level_in(pin_level_in),
        .pin_digital_oe_req(pin_digital_oe_req), .pin_read_value(pin_read_value),
        .pin_digital_oe(pin_digital_oe));
    drc_ladder_model #(.VDD_MV(VDD), .VREF_MV(VRP), .FIX_MV(FIX), .VNEG_MV(VNG))
        i_drc_ladder_model (.ladder(ladder_ctl), .vout_mv(vout_mv));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 rv = rd_data;
    endtask : rd

    // Two edges: one takes the write, the next shows it on the ladder
    task automatic settle;
        @(posedge ref_clk);
        bus_req <= '0;
        @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic t_reset_vals;
        chk(16'(ladder_ctl.pin_drive), 16'h0, "pin drive");
        chk(16'(ladder_ctl.tap), 16'h0, "tap");
        rd(OFS_MAIN);
        chk(16'(rv), 16'h0, "main");
        rd(OFS_LEVEL);
        chk(16'(rv), 16'h0, "level");
        $display("test reset_vals done");
    endtask : t_reset_vals

    task automatic t_fields;
        wr(OFS_MAIN, 8'hFF);
        rd(OFS_MAIN);
        chk(16'(rv), 16'h00ED, "main mask");
        @(posedge ref_clk);
        #1 chk(16'(rd_data), 16'h0, "rd data lingers");
        wr(OFS_LEVEL, 8'hFF);
        rd(OFS_LEVEL);
        chk(16'(rv), 16'h001F, "level mask");
        wr(2'h3, 8'hFF);
        wr(OFS_STATUS, 8'hFF);
        rd(2'h3);
        chk(16'(rv), 16'h0, "unmapped");
        rd(OFS_MAIN);
        chk(16'(rv), 16'h00ED, "main kept");
        $display("test fields done");
    endtask : t_fields

    task automatic t_sources;
        logic [2:0] ups [4];
        int         hv  [4];
        int         lo;
        ups = '{SRC_SUPPLY, SRC_EXT, SRC_FIXED, SRC_NONE};
        hv  = '{VDD, VRP, FIX, 0};
        wr(OFS_LEVEL, 8'h10);
        for (int p = 0; p < 4; p++) begin
            for (int n = 0; n < 2; n++) begin
                wr(OFS_MAIN, {1'b1, 3'b000, 2'(p), 1'b0, 1'(n)});
                settle();
                lo = n * VNG;
                chk(16'(ladder_ctl.upper_src), 16'(ups[p]), "upper src");
                chk(16'(ladder_ctl.lower_ext), 16'(n), "lower src");
                chk(16'(ladder_mode), 16'(MODE_ACTIVE), "enabled mode");
                chk(vout_mv[15:0], 16'(lo + (hv[p] - lo) / 2), "mid level");
            end
        end
        $display("test sources done");
    endtask : t_sources

    task automatic t_levels;
        wr(OFS_MAIN, 8'h80);
        for (int l = 0; l < 32; l++) begin
            wr(OFS_LEVEL, 8'(l));
            settle();
            chk(16'(ladder_ctl.tap), 16'(l), "tap");
            chk(vout_mv[15:0], 16'(VDD * l / 32), "level out");
        end
        $display("test levels done");
    endtask : t_levels

    task automatic t_lowpower;
        wr(OFS_MAIN, 8'h48);
        wr(OFS_LEVEL, 8'h1F);
        settle();
        chk(16'(ladder_mode), 16'(MODE_LOWER_OFF), "lps one mode");
        chk(16'({ladder_ctl.upper_end_on, ladder_ctl.lower_end_on}), 16'h2, "ends");
        chk(vout_mv[15:0], 16'(FIX), "clamp high");
        rd(OFS_STATUS);
        chk(16'(rv), 16'h000A, "status clamp high");
        wr(OFS_MAIN, 8'h01);
        wr(OFS_LEVEL, 8'h00);
        settle();
        chk(16'(ladder_mode), 16'(MODE_UPPER_OFF), "lps zero mode");
        chk(16'({ladder_ctl.upper_end_on, ladder_ctl.lower_end_on}), 16'h1, "ends");
        chk(vout_mv[15:0], 16'(VNG), "clamp low");
        rd(OFS_STATUS);
        chk(16'(rv), 16'h0014, "status clamp low");
        $display("test lowpower done");
    endtask : t_lowpower

    task automatic t_pin;
        wr(OFS_MAIN, 8'h20);
        pin_level_in <= 1'b1;
        pin_digital_oe_req <= 1'b1;
        @(posedge ref_clk);
        bus_req <= '0;
        #1 chk(16'(ladder_ctl.pin_drive), 16'h0, "drive early");
        @(posedge ref_clk);
        #1 chk(16'(ladder_ctl.pin_drive), 16'h1, "drive on");
        chk(16'(pin_digital_oe), 16'h0, "buffer override");
        @(posedge ref_clk);
        #1 chk(16'(pin_read_value), 16'h0, "pin reads zero");
        wr(OFS_MAIN, 8'h00);
        settle();
        @(posedge ref_clk);
        #1 chk(16'(pin_read_value), 16'h1, "pin read back");
        chk(16'(pin_digital_oe), 16'h1, "buffer back");
        $display("test pin done");
    endtask : t_pin

    task automatic t_retain;
        // Converter left disabled across the idle stretch to save current
        wr(OFS_MAIN, 8'h6D);
        wr(OFS_LEVEL, 8'h15);
        repeat (50) @(posedge ref_clk);
        rd(OFS_MAIN);
        chk(16'(rv), 16'h006D, "main kept");
        rd(OFS_LEVEL);
        chk(16'(rv), 16'h0015, "level kept");
        rd(OFS_STATUS);
        chk(16'(rv), 16'h0022, "status reserved src");
        wr(OFS_MAIN, 8'hA5);
        settle();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        #1 chk(16'(ladder_ctl.pin_drive), 16'h0, "async drive off");
        chk(16'(ladder_ctl.tap), 16'h0, "async tap");
        @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset_vals();
        $display("test retain done");
    endtask : t_retain

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    initial begin
        #1000000;
        err_total++;
        complete_run();
    end

    initial begin
        err_total = 0;
        compares = 0;
        rst_n = 1'b0;
        bus_req = '0;
        pin_level_in = 1'b0;
        pin_digital_oe_req = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset_vals();
        t_fields();
        t_sources();
        t_levels();
        t_lowpower();
        t_pin();
        t_retain();
        complete_run();
    end

endmodule : tb_top
`default_nettype wire
